// ### src/clock_gen_config_registers.sv
/*
  Configuration bank of a four-pll clock generator, programmed over a
  two-wire serial slave, with decoded settings for pins, outputs and the
  first pll.
  Assumes scl and sda are already synchronous to i_mclk and that the
  host keeps standard two-wire framing.
*/
//
// Contract
// - control bit picks pins or software select
// - software field chooses applied configuration set
// - associated outputs suspend on the shutdown pin
// - unassociated outputs stay enabled, ignore pin unless bit seven picks full shutdown
// - forced suspend low wins over association
// - pll suspend bits low stop pll
// - bit seven picks full shutdown or enable
// - reference bit picks crystal or input clock
// - five-bit trim sets crystal load capacitance
// - first pll reference divided by field
// - divider zero powers first pll down
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_config_defines.svh"

module clock_gen_config_registers
  import clock_gen_config_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // serial bus, sda is open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // device pins
  input wire logic [2:0] i_config_sel_pins,
  input wire logic i_shutdown_output_enable_pin,
  input wire logic [6:0] i_output_disable_style,
  // decoded settings
  output logic [2:0] o_active_config,
  output logic [6:0] o_output_enable,
  output logic [6:0] o_output_tristate,
  output logic [3:0] o_pll_run,
  output logic o_reference_source_sel,
  output logic [4:0] o_crystal_load_trim,
  output pll_a_cfg_t o_pll_a
);

  // register store wiring
  reg_image_t regs; // parallel view of all bytes
  logic mem_we; // one-cycle write strobe
  logic [7:0] rd_byte; // registered read data
  logic [7:0] rd_view; // read byte, zero past the last register
  logic [7:0] ptr; // register pointer set by host

  // serial engine state
  i2c_state_t state;
  logic scl_q; // previous scl sample
  logic sda_q; // previous sda sample
  logic [2:0] bit_cnt; // bit within the byte
  logic [7:0] shifter; // in or out byte
  logic byte_done; // eight bits received
  logic is_read; // direction of this transfer
  logic first_byte; // next written byte is the pointer
  logic drive_low; // pull sda low

  // decode helpers
  logic shutdown_pin_config; // pin acts as full shutdown
  logic pin_act; // shutdown pin asserted
  logic [6:0] next_enable;
  loop_filter_t sel_filter;
  logic [7:0] sel_div;

  // writable offsets exclude reserved bytes and anything past the end
  function automatic logic writable(input logic [7:0] a);
    writable = (a < 8'(`REG_COUNT)) && (a != `OFS_RSVD_06) &&
               (a != `OFS_RSVD_08) && (a != `OFS_RSVD_09);
  endfunction : writable

  // loop-filter register for a configuration set; sets 6 and 7 reuse 0
  function automatic logic [7:0] filter_of(input reg_image_t r,
                                           input logic [2:0] c);
    unique case (c)
      3'h1: filter_of = r[`OFS_LF_SET1];
      3'h2: filter_of = r[`OFS_LF_SET2];
      3'h3: filter_of = r[`OFS_LF_SET3];
      3'h4: filter_of = r[`OFS_LF_SET4];
      3'h5: filter_of = r[`OFS_LF_SET5];
      default: filter_of = r[`OFS_LF_SET0];
    endcase
  endfunction : filter_of

  // bus edges and framing conditions
  wire scl_rise = i_scl && !scl_q;
  wire scl_fall = !i_scl && scl_q;
  wire start_seen = i_scl && scl_q && sda_q && !i_sda;
  wire stop_seen = i_scl && scl_q && !sda_q && i_sda;

  // store holds every byte; read port follows the pointer
  config_reg_store u_store (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_we(mem_we),
    .i_waddr(ptr[4:0]),
    .i_wdata(shifter),
    .i_raddr(ptr[4:0]),
    .o_rdata(rd_byte),
    .o_image(regs)
  );

  // sda is only ever pulled low, never driven high
  assign o_sda = 1'b0;
  assign o_sda_oe = drive_low;

  // the store only sees five pointer bits, so high pointers must not alias
  assign rd_view = (ptr < 8'(`REG_COUNT)) ? rd_byte : 8'h00;

  // previous samples for edge detection
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // write strobe: a data byte after the pointer byte, writable offsets
  assign mem_we = (state == ST_WR_BYTE) && scl_fall && byte_done &&
                  !first_byte && writable(ptr);

  // serial slave: bits taken on scl rise, sda changed on scl fall
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shifter <= 8'h00;
      byte_done <= 1'b0;
      is_read <= 1'b0;
      first_byte <= 1'b0;
      drive_low <= 1'b0;
      ptr <= 8'h00;
    end else if (start_seen) begin
      // repeated start restarts framing but keeps the pointer
      state <= ST_ADDR;
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      drive_low <= 1'b0;
    end else if (stop_seen) begin
      state <= ST_IDLE;
      drive_low <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          drive_low <= 1'b0;
        end
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            shifter <= {shifter[6:0], i_sda};
            bit_cnt <= bit_cnt + 3'h1;
            byte_done <= (bit_cnt == 3'h7);
          end else if (scl_fall && byte_done) begin
            byte_done <= 1'b0;
            if (state == ST_ADDR) begin
              // answer only our own address
              if (shifter[7:1] == `I2C_DEV_ADDR) begin
                is_read <= shifter[0];
                first_byte <= !shifter[0];
                drive_low <= 1'b1;
                state <= ST_ACK_ADDR;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              // first byte loads the pointer, later ones write and step
              if (first_byte) begin
                ptr <= shifter;
              end else begin
                ptr <= ptr + 8'h01;
              end
              first_byte <= 1'b0;
              drive_low <= 1'b1;
              state <= ST_ACK_WR;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_WR: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (state == ST_ACK_ADDR && is_read) begin
              // present the addressed byte, msb first
              shifter <= rd_view;
              drive_low <= !rd_view[7];
              ptr <= ptr + 8'h01;
              state <= ST_RD_BYTE;
            end else begin
              drive_low <= 1'b0;
              state <= ST_WR_BYTE;
            end
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt == 3'h7) begin
              drive_low <= 1'b0; // release for host acknowledge
              state <= ST_ACK_RD;
            end else begin
              shifter <= {shifter[6:0], 1'b0};
              drive_low <= !shifter[6];
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        end
        ST_ACK_RD: begin
          if (scl_rise && i_sda) begin
            state <= ST_IDLE; // host declined more data
          end else if (scl_fall) begin
            shifter <= rd_view;
            drive_low <= !rd_view[7];
            ptr <= ptr + 8'h01;
            bit_cnt <= 3'h0;
            state <= ST_RD_BYTE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // mode decode; shutdown mode silences everything the pin reaches
  assign shutdown_pin_config = regs[`OFS_PLL_SUSP][`BIT_SHUTDOWN_CFG];
  assign pin_act = i_shutdown_output_enable_pin;

  // forced suspend first, then full shutdown or pin association per output
  always_comb begin
    next_enable = regs[`OFS_FORCED_SUSP][6:0];
    if (shutdown_pin_config && pin_act) begin
      next_enable = 7'h00;
    end else if (pin_act) begin
      next_enable = next_enable & ~regs[`OFS_SUSP_ASSOC][6:0];
    end
  end

  // active configuration source
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_active_config <= 3'h0;
    end else if (regs[`OFS_CTRL_SRC][`BIT_CTRL_SRC]) begin
      o_active_config <= regs[`OFS_SW_SEL][2:0];
    end else begin
      o_active_config <= i_config_sel_pins;
    end
  end

  // output enables and disable style for suspended outputs
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_output_enable <= 7'h00;
      o_output_tristate <= 7'h00;
    end else begin
      o_output_enable <= next_enable;
      o_output_tristate <= ~next_enable & i_output_disable_style;
    end
  end

  // pll run bits; full shutdown stops all four
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pll_run <= 4'h0;
    end else if (shutdown_pin_config && pin_act) begin
      o_pll_run <= 4'h0;
    end else begin
      o_pll_run <= regs[`OFS_PLL_SUSP][3:0];
    end
  end

  // reference source and crystal trim
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reference_source_sel <= 1'b0;
      o_crystal_load_trim <= 5'h00;
    end else begin
      o_reference_source_sel <= regs[`OFS_REF_SRC][`BIT_REF_SRC];
      o_crystal_load_trim <= regs[`OFS_XTAL_TRIM][4:0];
    end
  end

  // first pll settings for the active set; divider per set 0..2
  assign sel_filter = filter_of(regs, o_active_config);
  always_comb begin
    unique case (o_active_config)
      3'h1: sel_div = regs[`OFS_DIV_11];
      3'h2: sel_div = regs[`OFS_DIV_12];
      default: sel_div = regs[`OFS_DIV_10];
    endcase
  end

  // divider zero means power down rather than divide
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pll_a <= '0;
    end else begin
      o_pll_a.filter <= sel_filter;
      o_pll_a.ref_divider <= sel_div[6:0];
      o_pll_a.power_down <= (sel_div[6:0] == 7'h00);
    end
  end

  // checks on the decoded settings and the serial slave
  default clocking cb @(posedge i_mclk); endclocking
  // checks start one edge after release; outputs still hold reset values
  logic armed;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end
  default disable iff (!i_reset_n || !armed);

  pin_mode_a: assert property (
    !regs[`OFS_CTRL_SRC][0] |=> o_active_config == $past(i_config_sel_pins))
    else $error("active config not from pins");
  sw_mode_a: assert property (
    regs[`OFS_CTRL_SRC][0] |=> o_active_config == $past(regs[1][2:0]))
    else $error("active config not from software field");
  assoc_suspend_a: assert property (
    (!shutdown_pin_config && pin_act && regs[2][0] && regs[3][0]) |=>
      !o_output_enable[0] && (o_output_tristate[0] ==
      $past(i_output_disable_style[0])))
    else $error("associated output not suspended");
  assoc_off_a: assert property (
    (!shutdown_pin_config && !regs[2][1] && regs[3][1]) |=>
      o_output_enable[1])
    else $error("unassociated output disabled");
  forced_suspend_a: assert property (
    1'b1 |=> (o_output_enable & ~$past(regs[3][6:0])) == 7'h00)
    else $error("forced suspend ignored");
  pll_run_a: assert property (
    !pin_act |=> o_pll_run == $past(regs[4][3:0]))
    else $error("pll run bits wrong");
  full_shutdown_a: assert property (
    (shutdown_pin_config && pin_act) |=> (o_pll_run == 4'h0) &&
      (o_output_enable == 7'h00))
    else $error("shutdown did not stop plls and outputs");
  ref_trim_a: assert property (
    1'b1 |=> o_reference_source_sel == $past(regs[5][4]) &&
      o_crystal_load_trim == $past(regs[7][4:0]))
    else $error("reference or trim not applied");
  div_power_a: assert property (
    1'b1 |=> o_pll_a.power_down == (o_pll_a.ref_divider == 7'h00))
    else $error("divider zero power down mismatch");
  filter_sel_a: assert property (
    $stable(o_active_config) && $stable(regs) |=>
      o_pll_a.filter == $past(sel_filter))
    else $error("loop filter not from active set");
  write_store_a: assert property (
    mem_we |=> regs[$past(ptr[4:0])] == $past(shifter))
    else $error("written byte not stored");

  addr_ack_c: cover property (state == ST_ACK_ADDR);
  reg_write_c: cover property (mem_we);
  read_byte_c: cover property (state == ST_ACK_RD);
  shutdown_c: cover property (shutdown_pin_config && pin_act);

endmodule : clock_gen_config_registers
`default_nettype wire

// ### include/clock_gen_config_defines.svh
/*
  Offsets, field positions and reset values of the configuration bank.
  Assumes inclusion by bare name from any file that needs them.
*/
`ifndef CLOCK_GEN_CONFIG_DEFINES_SVH
`define CLOCK_GEN_CONFIG_DEFINES_SVH

// register count and byte offsets
`define REG_COUNT 19
`define OFS_CTRL_SRC 8'h00
`define OFS_SW_SEL 8'h01
`define OFS_SUSP_ASSOC 8'h02
`define OFS_FORCED_SUSP 8'h03
`define OFS_PLL_SUSP 8'h04
`define OFS_REF_SRC 8'h05
`define OFS_RSVD_06 8'h06
`define OFS_XTAL_TRIM 8'h07
`define OFS_RSVD_08 8'h08
`define OFS_RSVD_09 8'h09
`define OFS_LF_SET4 8'h0a
`define OFS_LF_SET5 8'h0b
`define OFS_LF_SET0 8'h0c
`define OFS_LF_SET1 8'h0d
`define OFS_LF_SET2 8'h0e
`define OFS_LF_SET3 8'h0f
`define OFS_DIV_10 8'h10
`define OFS_DIV_11 8'h11
`define OFS_DIV_12 8'h12

// reset values
`define RST_CTRL_SRC 8'h00
`define RST_SW_SEL 8'h00
`define RST_SUSP_ASSOC 8'h02
`define RST_FORCED_SUSP 8'h02
`define RST_PLL_SUSP 8'h0f
`define RST_REF_SRC 8'h04
`define RST_XTAL_TRIM 8'h00
`define RST_LOOP_FILTER 8'h10
`define RST_DIVIDER 8'h00
`define RST_RESERVED 8'h00

// field positions
`define BIT_CTRL_SRC 0
`define BIT_SHUTDOWN_CFG 7
`define BIT_REF_SRC 4
`define BIT_ZERO_CAP 7

// bus address of the device, arbitrary value
`define I2C_DEV_ADDR 7'h5a

`endif

// ### include/clock_gen_config_pkg.sv
/*
  Types shared by the configuration bank and its register store.
  Assumes the defines header is on the include path.
*/
package clock_gen_config_pkg;

  // whole register image, index equals byte offset
  typedef logic [18:0][7:0] reg_image_t;

  // one loop-filter register
  typedef struct packed {
    logic zero_cap;
    logic [2:0] pump_current;
    logic [3:0] zero_resistor;
  } loop_filter_t;

  // settings handed to the first pll
  typedef struct packed {
    loop_filter_t filter;
    logic [6:0] ref_divider;
    logic power_down;
  } pll_a_cfg_t;

  // serial slave states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WR_BYTE, ST_ACK_WR, ST_RD_BYTE,
    ST_ACK_RD
  } i2c_state_t;

endpackage : clock_gen_config_pkg

// ### src/config_reg_store.sv
/*
  Byte register store with one write port, one registered read port and
  a parallel view of every byte.
  Assumes the caller masks writes to reserved or unmapped offsets.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_config_defines.svh"

module config_reg_store
  import clock_gen_config_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // write port
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // read port
  input wire logic [4:0] i_raddr,
  output logic [7:0] o_rdata,
  // parallel view
  output reg_image_t o_image
);

  // reset image laid out at the byte offsets
  localparam reg_image_t RESET_IMAGE = {
    `RST_DIVIDER, `RST_DIVIDER, `RST_DIVIDER,
    `RST_LOOP_FILTER, `RST_LOOP_FILTER, `RST_LOOP_FILTER,
    `RST_LOOP_FILTER, `RST_LOOP_FILTER, `RST_LOOP_FILTER,
    `RST_RESERVED, `RST_RESERVED, `RST_XTAL_TRIM, `RST_RESERVED,
    `RST_REF_SRC, `RST_PLL_SUSP, `RST_FORCED_SUSP, `RST_SUSP_ASSOC,
    `RST_SW_SEL, `RST_CTRL_SRC};

  // storage, written one byte at a time
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_image <= RESET_IMAGE;
    end else if (i_we && (i_waddr < 5'(`REG_COUNT))) begin
      o_image[i_waddr] <= i_wdata;
    end
  end

  // registered read; out-of-range offsets read as zero
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_raddr < 5'(`REG_COUNT)) begin
      o_rdata <= o_image[i_raddr];
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule : config_reg_store
`default_nettype wire

// ### testbench/i2c_host_model.sv
/*
  Behavioural two-wire host that programs the configuration bank.
  Assumes a pull-up on sda and scl owned by the host alone; every line
  changes just after a rising edge of i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_config_defines.svh"

module i2c_host_model (
  // clock
  input wire logic i_mclk,
  // device pull on the data line
  input wire logic i_sda_oe,
  // bus lines as seen on the wire
  output logic o_scl,
  output logic o_sda
);
  logic sda_drv; // host value, 1 = released to the pull-up

  // wired-and: a released line floats to the pull-up level
  assign o_sda = sda_drv & ~i_sda_oe;

  // idle bus at time zero
  initial begin
    o_scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : hold

  // start or repeated start; phases of four cycles keep the 3 cycle minimum
  task automatic start_cond();
    sda_drv <= 1'b1;
    hold(4);
    o_scl <= 1'b1;
    hold(4);
    sda_drv <= 1'b0;
    hold(4);
    o_scl <= 1'b0;
    hold(1);
  endtask : start_cond

  task automatic stop_cond();
    sda_drv <= 1'b0;
    hold(4);
    o_scl <= 1'b1;
    hold(4);
    sda_drv <= 1'b1;
    hold(4);
  endtask : stop_cond

  // one bit; sda moves one cycle after scl fell, never while scl is high
  task automatic clock_bit(input logic b, output logic seen);
    sda_drv <= b;
    hold(4);
    o_scl <= 1'b1;
    hold(4);
    seen = o_sda;
    o_scl <= 1'b0;
    hold(1);
  endtask : clock_bit

  // byte out msb first, then the ack slot left released
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], s);
    end
    clock_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // byte in msb first; a nack ends the read
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, d[i]);
    end
    clock_bit(last, s);
  endtask : recv_byte

  // pointer then one or two data bytes, auto-increment does the rest
  task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d0,
                            input logic [7:0] d1, input logic two,
                            output logic ok);
    logic a0, a1, a2, a3;
    start_cond();
    send_byte({`I2C_DEV_ADDR, 1'b0}, a0);
    send_byte(ptr, a1);
    send_byte(d0, a2);
    a3 = 1'b1;
    if (two) begin
      send_byte(d1, a3);
    end
    stop_cond();
    ok = a0 & a1 & a2 & a3;
  endtask : write_regs

  // pointer write, repeated start, one byte read with nack
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d,
                          output logic ok);
    logic a0, a1, a2;
    start_cond();
    send_byte({`I2C_DEV_ADDR, 1'b0}, a0);
    send_byte(ptr, a1);
    start_cond();
    send_byte({`I2C_DEV_ADDR, 1'b1}, a2);
    recv_byte(1'b1, d);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

// ### testbench/clock_gen_config_registers_tb_top.sv
/*
  Self-checking bench for the configuration bank.
  Assumes the host model above and the defines header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_config_defines.svh"

module clock_gen_config_registers_tb_top
  import clock_gen_config_pkg::*;
;
  logic i_mclk = 1'b0; // 10 MHz
  logic i_reset_n = 1'b0;
  logic scl, sda, sda_oe, sda_val;
  logic [2:0] pins = 3'h6; // nonzero so the pin path is visible
  logic sd_pin = 1'b0;
  logic [6:0] style = 7'h55;
  logic [2:0] active;
  logic [6:0] out_en, out_tri;
  logic [3:0] pll_run;
  logic ref_sel;
  logic [4:0] trim;
  pll_a_cfg_t pll_a;
  int n_mismatch = 0;
  int comparisons = 0;

  always #50 i_mclk = ~i_mclk;

  i2c_host_model u_host (.i_mclk(i_mclk), .i_sda_oe(sda_oe), .o_scl(scl),
                         .o_sda(sda));

  clock_gen_config_registers u_dut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda),
    .o_sda(sda_val), .o_sda_oe(sda_oe), .i_config_sel_pins(pins),
    .i_shutdown_output_enable_pin(sd_pin), .i_output_disable_style(style),
    .o_active_config(active), .o_output_enable(out_en),
    .o_output_tristate(out_tri), .o_pll_run(pll_run),
    .o_reference_source_sel(ref_sel), .o_crystal_load_trim(trim),
    .o_pll_a(pll_a));

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // write then let the decoded outputs settle after the stop
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    u_host.write_regs(p, d, 8'h00, 1'b0, ok);
    chk("write ack", 16'h1, {15'h0, ok});
    repeat (3) @(posedge i_mclk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.read_reg(p, d, ok);
    chk("read ack", 16'h1, {15'h0, ok});
    chk("read data", {8'h0, exp}, {8'h0, d});
  endtask : rd_chk

  // every register at its default over the bus; outputs other than trim and tristate at reset
  task automatic check_reset_values();
    logic [7:0] tab [19];
    tab = '{`RST_CTRL_SRC, `RST_SW_SEL, `RST_SUSP_ASSOC, `RST_FORCED_SUSP,
            `RST_PLL_SUSP, `RST_REF_SRC, `RST_RESERVED, `RST_XTAL_TRIM,
            `RST_RESERVED, `RST_RESERVED, `RST_LOOP_FILTER,
            `RST_LOOP_FILTER, `RST_LOOP_FILTER, `RST_LOOP_FILTER,
            `RST_LOOP_FILTER, `RST_LOOP_FILTER, `RST_DIVIDER, `RST_DIVIDER,
            `RST_DIVIDER};
    chk("active", 16'h6, active);
    chk("out_en", 16'h02, out_en);
    chk("pll_run", 16'hf, pll_run);
    chk("ref_sel", 16'h0, ref_sel);
    chk("pll_a", {8'h10, 7'h00, 1'b1}, pll_a);
    for (int i = 0; i < `REG_COUNT; i++) begin
      rd_chk(8'(i), tab[i]);
    end
  endtask : check_reset_values

  // trim, reserved and unmapped places, refused device address
  task automatic check_data_path();
    logic ack;
    wr(`OFS_XTAL_TRIM, 8'h55);
    chk("trim", 16'h15, trim);
    rd_chk(`OFS_XTAL_TRIM, 8'h55);
    wr(`OFS_RSVD_06, 8'hff);
    rd_chk(`OFS_RSVD_06, 8'h00);
    wr(8'h13, 8'h3c);
    rd_chk(8'h13, 8'h00);
    wr(`OFS_REF_SRC, 8'h10);
    chk("ref_sel", 16'h1, ref_sel);
    u_host.start_cond();
    u_host.send_byte({`I2C_DEV_ADDR ^ 7'h01, 1'b0}, ack);
    u_host.stop_cond();
    chk("foreign addr ack", 16'h0, ack);
    chk("sda value", 16'h0, sda_val);
  endtask : check_data_path

  // pins versus software select, loop filter and divider per set
  task automatic check_config_select();
    logic ok;
    pins <= 3'h5;
    repeat (3) @(posedge i_mclk);
    chk("active pins", 16'h5, active);
    u_host.write_regs(`OFS_CTRL_SRC, 8'h01, 8'h03, 1'b1, ok);
    repeat (3) @(posedge i_mclk);
    chk("pair ack", 16'h1, ok);
    chk("active sw", 16'h3, active);
    wr(`OFS_LF_SET3, 8'ha5);
    chk("filter", 16'h00a5, pll_a.filter);
    wr(`OFS_SW_SEL, 8'h01);
    wr(`OFS_DIV_11, 8'h05);
    chk("pll_a", {8'h10, 7'h05, 1'b0}, pll_a);
    wr(`OFS_DIV_11, 8'h00);
    chk("pll_a off", {8'h10, 7'h00, 1'b1}, pll_a);
    rd_chk(8'h20, 8'h00);
    wr(`OFS_SW_SEL, 8'h04);
    wr(`OFS_LF_SET4, 8'h3c);
    chk("filter set4", 16'h003c, pll_a.filter);
    wr(`OFS_SW_SEL, 8'h02);
    wr(`OFS_DIV_12, 8'h7f);
    chk("div set2", 16'h007f, pll_a.ref_divider);
  endtask : check_config_select

  // pin association, forced suspend, pll suspend and shutdown bit
  task automatic check_suspend();
    wr(`OFS_SUSP_ASSOC, 8'h03);
    wr(`OFS_FORCED_SUSP, 8'h7f);
    sd_pin <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk("out_en pin", 16'h7c, out_en);
    chk("out_tri pin", 16'h01, out_tri);
    chk("pll_run pin", 16'hf, pll_run);
    sd_pin <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk("out_en free", 16'h7f, out_en);
    wr(`OFS_FORCED_SUSP, 8'h7e);
    chk("out_en forced", 16'h7e, out_en);
    wr(`OFS_PLL_SUSP, 8'h05);
    chk("pll_run", 16'h5, pll_run);
    wr(`OFS_PLL_SUSP, 8'h8f);
    sd_pin <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk("pll_run shut", 16'h0, pll_run);
    chk("out_en shut", 16'h00, out_en);
    sd_pin <= 1'b0;
  endtask : check_suspend

  // hang guard
  initial begin
    repeat (100000) @(posedge i_mclk);
    n_mismatch++;
    close_out();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    check_reset_values();
    check_data_path();
    check_config_select();
    check_suspend();
    close_out();
  end
endmodule : clock_gen_config_registers_tb_top
`default_nettype wire
